// [logic/asc_pkg.sv]
// Contract
// R1 - memory holds 1M words of 16 bits, 20-bit word address, word-wide strap
// R2 - device idles when select_n high, select_hi low, or both lane enables high
// R3 - data pins float when deselected, gate high, both lanes off, or writing
// R4 - host writes with select_n low, select_hi high, strobe low, address presented
// R5 - write stores low byte if low lane enabled, high byte if high lane enabled
// R6 - host reads with select_n low, select_hi high, gate low, strobe high
// R7 - read drives low byte when low lane enable is low
// R8 - read drives high byte when high lane enable is low
// R9 - width strap high gives word-wide part; low gives byte-wide double depth
// R10 - byte-wide mode adds extra_top_addr; lane enables and pins 8..14 unused
// R11 - host releases data bus on reads, drives write data only while strobe low
package asc_pkg;
  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;
  // ---------------------------------------------------------------
  // timing, in ns at the reference clock
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETUP_NS = 10;
  localparam int STROBE_NS = 60;
  localparam int HOLD_NS = 10;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ASC_IDLE = 4'h1,
    ASC_SETUP = 4'h2,
    ASC_STROBE = 4'h4,
    ASC_HOLD = 4'h8
  } asc_state_e;
endpackage : asc_pkg

// [logic/asc_host.sv]
`timescale 1ns/1ps
module asc_host
  import asc_pkg::*;
#(
  parameter int P_ADDR_W = ADDR_W // word address of the 1M x 16 part, see R1
) (
  // clock, reset, enable
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  // user request
  input wire logic i_req,
  input wire logic i_req_write,
  input wire logic [P_ADDR_W-1:0] i_req_addr,
  input wire logic [1:0] i_req_lane_n,
  input wire logic [DATA_W-1:0] i_req_wdata,
  input wire logic i_byte_mode,
  output logic o_busy,
  output logic o_done,
  output logic [DATA_W-1:0] o_rdata,
  // memory pins
  output logic o_select_n,
  output logic o_select_hi,
  output logic o_out_gate_n,
  output logic o_write_n,
  output logic o_low_lane_en_n,
  output logic o_high_lane_en_n,
  output logic [P_ADDR_W-1:0] o_addr,
  output logic o_extra_top_addr,
  output logic [DATA_W-1:0] o_data_out,
  output logic o_data_oe_n,
  input wire logic [DATA_W-1:0] i_data_in
);
  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  asc_state_e state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic wr_reg;
  logic [DATA_W-1:0] s1_reg, s2_reg, s3_reg;

  // timing walk: setup, strobe, hold; each phase counted down
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= ASC_IDLE;
      cnt_reg <= '0;
      wr_reg <= 1'b0;
    end else if (i_clk_en) begin
      case (state_reg)
        ASC_IDLE: begin
          if (i_req) begin
            state_reg <= ASC_SETUP;
            wr_reg <= i_req_write;
            cnt_reg <= CNT_W'(SETUP_CYC - 1);
          end
        end
        ASC_SETUP: begin
          if (cnt_reg == '0) begin
            state_reg <= ASC_STROBE;
            cnt_reg <= CNT_W'(STROBE_CYC - 1);
          end else cnt_reg <= cnt_reg - 1'b1;
        end
        ASC_STROBE: begin
          if (cnt_reg == '0) begin
            state_reg <= ASC_HOLD;
            cnt_reg <= CNT_W'(HOLD_CYC - 1);
          end else cnt_reg <= cnt_reg - 1'b1;
        end
        ASC_HOLD: begin
          if (cnt_reg == '0) state_reg <= ASC_IDLE;
          else cnt_reg <= cnt_reg - 1'b1;
        end
        default: state_reg <= ASC_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  // phase boundaries shared by the pin processes; the states are exclusive,
  // so at most one of these is high in any cycle
  logic take_w;
  logic setup_end_w;
  logic strobe_end_w;
  logic hold_end_w;
  assign take_w = (state_reg == ASC_IDLE) && i_req;
  assign setup_end_w = (state_reg == ASC_SETUP) && (cnt_reg == '0);
  assign strobe_end_w = (state_reg == ASC_STROBE) && (cnt_reg == '0);
  assign hold_end_w = (state_reg == ASC_HOLD) && (cnt_reg == '0);

  // chip selects: active from take to end of hold; idle leaves the part
  // in standby so its data pins float (see R2, see R3)
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_select_n <= 1'b1;
      o_select_hi <= 1'b0;
    end else if (i_clk_en) begin
      if (take_w) begin
        o_select_n <= 1'b0; // see R4, see R6
        o_select_hi <= 1'b1;
      end else if (hold_end_w) begin
        o_select_n <= 1'b1; // see R2
        o_select_hi <= 1'b0;
      end
    end
  end

  // address: loaded once at take and held for the whole access, so the
  // part never sees it move while selected (see R1)
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_addr <= '0;
      o_extra_top_addr <= 1'b0;
    end else if (i_clk_en && take_w) begin
      o_addr <= i_req_addr;
      // byte mode: lane bit 0 carries the extra address bit (see R10, see R9)
      o_extra_top_addr <= i_byte_mode ? i_req_lane_n[0] : 1'b0;
    end
  end

  // lane enables: byte mode parks both high, the pins are unused there;
  // word mode passes the request's lanes straight through
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_low_lane_en_n <= 1'b1;
      o_high_lane_en_n <= 1'b1;
    end else if (i_clk_en) begin
      if (take_w) begin
        o_low_lane_en_n <= i_byte_mode ? 1'b1 : i_req_lane_n[0]; // see R5, see R7
        o_high_lane_en_n <= i_byte_mode ? 1'b1 : i_req_lane_n[1]; // see R8
      end else if (hold_end_w) begin
        o_low_lane_en_n <= 1'b1;
        o_high_lane_en_n <= 1'b1;
      end
    end
  end

  // output gate: low for reads only; raised with the end of strobe so the
  // part lets go of the bus a full hold before the selects drop (see R6)
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_out_gate_n <= 1'b1;
    end else if (i_clk_en) begin
      if (take_w) begin
        o_out_gate_n <= i_req_write;
      end else if (strobe_end_w) begin
        o_out_gate_n <= 1'b1;
      end
    end
  end

  // write strobe: low through the strobe phase of a write only; a setup
  // phase in front keeps address and lanes settled before it falls
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_write_n <= 1'b1;
    end else if (i_clk_en) begin
      if (setup_end_w) begin
        o_write_n <= ~wr_reg; // see R4
      end else if (strobe_end_w) begin
        o_write_n <= 1'b1;
      end
    end
  end

  // data drive: enabled only while the strobe is low, so host and part
  // never fight over the bus; costs nothing since reads need no drive
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_data_out <= '0;
      o_data_oe_n <= 1'b1;
    end else if (i_clk_en) begin
      if (take_w) begin
        o_data_out <= i_req_wdata;
        o_data_oe_n <= 1'b1; // see R11
      end else if (setup_end_w) begin
        o_data_oe_n <= ~wr_reg; // drive only while strobe low, see R11
      end else if (strobe_end_w) begin
        o_data_oe_n <= 1'b1; // see R11
      end
    end
  end

  // ---------------------------------------------------------------
  // read data capture
  // ---------------------------------------------------------------
  // three-stage sampler; only stages two and three are looked at
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else if (i_clk_en) begin
      s1_reg <= i_data_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // handshake flags: done pulses for the cycle after the last hold edge
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_done <= 1'b0;
      o_busy <= 1'b0;
    end else if (i_clk_en) begin
      o_done <= hold_end_w;
      // a raised request shows busy from the next edge, the same edge that takes it out of idle
      o_busy <= (state_reg != ASC_IDLE) || i_req;
    end
  end

  // capture at end of hold; data settled long before (see R7, see R8)
  // a word whose last two samples disagree is dropped and the old one kept
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= '0;
    end else if (i_clk_en) begin
      if (hold_end_w && !wr_reg && s2_reg == s3_reg) begin
        o_rdata <= s3_reg;
      end
    end
  end
endmodule : asc_host

// [tb/asc_host_assertions.sv]
`timescale 1ns/1ps
module asc_host_assertions (
  input wire logic i_ref_clk, i_reset_n, i_req, o_busy, o_done,
  input wire logic o_select_n, o_select_hi, o_out_gate_n, o_write_n, o_data_oe_n
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  // a transfer is taken in idle and answered a fixed count later
  sequence s_take; i_req && !o_busy; endsequence
  sequence s_end; o_done && o_select_n; endsequence
  a_done_delay: assert property (s_take |-> ##9 s_end)
    else $error("done not nine cycles after take");
  a_write_sel: assert property (!o_write_n |-> !o_select_n && o_select_hi && o_out_gate_n)
    else $error("strobe low while not selected");
  a_strobe_len: assert property ($fell(o_write_n) |-> !o_write_n [*6] ##1 o_write_n)
    else $error("strobe width off");
  a_read_sel: assert property (!o_out_gate_n |-> !o_select_n && o_select_hi && o_write_n)
    else $error("gate low without read select");
  a_drive_win: assert property (!o_data_oe_n |-> !o_write_n && o_out_gate_n)
    else $error("data driven outside strobe");
endmodule : asc_host_assertions
bind asc_host asc_host_assertions asc_host_assertions_inst (.i_ref_clk, .i_reset_n, .i_req,
  .o_busy, .o_done, .o_select_n, .o_select_hi, .o_out_gate_n, .o_write_n, .o_data_oe_n);

// [tb/asc_sram_model.sv]
`timescale 1ns/1ps
module asc_sram_model (
  input wire logic i_smp_clk,
  input wire logic i_sel_n, i_sel_hi, i_gate_n, i_wr_n, i_lo_n, i_hi_n,
  input wire logic [19:0] i_addr,
  input wire logic [15:0] i_bus,
  output logic [15:0] o_q
);
  logic [15:0] mem [int]; // sparse 1M x 16
  logic on, rd;
  assign on = !i_sel_n && i_sel_hi && !(i_lo_n && i_hi_n);
  assign rd = on && !i_gate_n && i_wr_n;
  // sampled mid-cycle so the strobe and data edges never race
  always @(negedge i_smp_clk) if (on && !i_wr_n) begin
    if (!i_lo_n) mem[i_addr][7:0] = i_bus[7:0];
    if (!i_hi_n) mem[i_addr][15:8] = i_bus[15:8];
  end
  // floating lanes show a toggling pattern, never the last value
  always @* begin
    o_q = 16'hA55A ^ {16{i_smp_clk}};
    if (rd && mem.exists(i_addr)) begin
      if (!i_lo_n) o_q[7:0] = mem[i_addr][7:0];
      if (!i_hi_n) o_q[15:8] = mem[i_addr][15:8];
    end
  end
endmodule : asc_sram_model

// [tb/test_asc_host.sv]
`timescale 1ns/1ps
module test_asc_host;
  logic i_ref_clk = 0, i_reset_n = 0, i_req = 0, i_req_write = 0;
  logic [19:0] i_req_addr = '0, o_addr;
  logic [1:0] i_req_lane_n = '0;
  logic [15:0] i_req_wdata = '0, o_rdata, o_data_out, bus, q;
  logic o_busy, o_done, sn, sh, gn, wn, lo, hi, oen;
  int errors = 0, samples_checked = 0;
  logic [15:0] ref_mem [int];
  always #5 i_ref_clk = ~i_ref_clk;
  assign bus = oen ? q : o_data_out;
  asc_host asc_host_inst (.i_ref_clk, .i_reset_n, .i_clk_en(1'b1), .i_req, .i_req_write,
    .i_req_addr, .i_req_lane_n, .i_req_wdata, .i_byte_mode(1'b0), .o_busy, .o_done,
    .o_rdata, .o_select_n(sn), .o_select_hi(sh), .o_out_gate_n(gn), .o_write_n(wn),
    .o_low_lane_en_n(lo), .o_high_lane_en_n(hi), .o_addr, .o_extra_top_addr(),
    .o_data_out, .o_data_oe_n(oen), .i_data_in(bus));
  asc_sram_model asc_sram_model_inst (.i_smp_clk(i_ref_clk), .i_sel_n(sn), .i_sel_hi(sh),
    .i_gate_n(gn), .i_wr_n(wn), .i_lo_n(lo), .i_hi_n(hi), .i_addr(o_addr), .i_bus(bus),
    .o_q(q));
  task automatic check(input string what, input logic [15:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask : check
  // one request, then a bounded wait for done, a latency check, and a reference update on writes or a data check on reads
  task automatic xfer(input logic wr, input logic [19:0] a, input logic [1:0] ln,
    input logic [15:0] d);
    int n = 0;
    @(negedge i_ref_clk);
    {i_req, i_req_write, i_req_addr, i_req_lane_n, i_req_wdata} = {1'b1, wr, a, ln, d};
    @(negedge i_ref_clk);
    i_req = 0;
    while (o_done !== 1'b1 && n < 20) begin
      @(negedge i_ref_clk);
      n++;
    end
    check("latency", 16'h8, 16'(n));
    if (wr) begin
      for (int b = 0; b < 2; b++) if (!ln[b]) ref_mem[a][b*8+:8] = d[b*8+:8];
    end else check("rdata", ref_mem[a], o_rdata);
  endtask : xfer
  task automatic close_out;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  // full write, lane-coded rewrite (code 3 stores nothing), then read back
  initial begin
    logic [19:0] a;
    void'($urandom(32'h74C2));
    repeat (6) @(negedge i_ref_clk);
    i_reset_n = 1;
    for (int i = 0; i < 8; i++) begin
      a = 20'($urandom);
      xfer(1'b1, a, 2'h0, 16'($urandom));
      xfer(1'b1, a, 2'(i % 4), 16'($urandom));
      xfer(1'b0, a, 2'h0, 16'h0);
    end
    close_out;
  end
  initial begin
    #20000;
    errors++;
    close_out;
  end
endmodule : test_asc_host
